// file: src/fls_sequencer.sv
// Mode decoder, charge sequencer and AXI4-Lite register slave
`default_nettype none
module fls_sequencer
   import fls_pkg::*;
(
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   input  wire  logic        enable_pin,
   input  wire  logic        fill_pin,
   input  wire  fls_cmp_s    cmp_in,
   input  wire  logic [7:0]  s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output var   logic        s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output var   logic        s_axi_wready,
   output var   logic [1:0]  s_axi_bresp,
   output var   logic        s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   input  wire  logic [7:0]  s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output var   logic        s_axi_arready,
   output var   logic [31:0] s_axi_rdata,
   output var   logic [1:0]  s_axi_rresp,
   output var   logic        s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   output var   fls_pwr_s    pwr_out,
   output var   logic        full_indicator,
   output var   fls_mode_e   mode_out
);

   // Pin and comparator synchronisers
   logic [8:0] sync1_reg;
   logic [8:0] sync2_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 9'h000;
         sync2_reg <= 9'h000;
      end else begin
         sync1_reg <= {enable_pin, fill_pin, cmp_in};
         sync2_reg <= sync1_reg;
      end
   end
   fls_cmp_s cmp;
   logic     en_s;
   logic     fill_s;
   assign {en_s, fill_s} = sync2_reg[8:7];
   assign cmp = fls_cmp_s'(sync2_reg[6:0]);

   // Enable low: held reset of registers, mode, phase and outputs; bus channels keep running
   logic srst;
   assign srst = !aresetn || !en_s;

   // Software registers
   logic [31:0] ctrl_reg;
   logic [31:0] cfg_reg;

   // Field views
   logic       fill_bit;
   logic       burst_bit;
   logic       steady_bit;
   logic [1:0] drain_select;
   logic [1:0] fill_current;
   logic [2:0] inductor_peak_select;
   logic       high_output_peak_select;
   logic [2:0] target_voltage_select;
   assign fill_bit                = ctrl_reg[CTRL_FILL_BIT];
   assign burst_bit               = ctrl_reg[CTRL_BURST_BIT];
   assign steady_bit              = ctrl_reg[CTRL_STEADY_BIT];
   assign drain_select            = ctrl_reg[CTRL_DRAIN_LSB +: 2];
   assign fill_current            = cfg_reg[CFG_FILL_I_LSB +: 2];
   assign inductor_peak_select    = cfg_reg[CFG_PEAK_LSB +: 3];
   assign high_output_peak_select = cfg_reg[CFG_HIGH_PK_BIT];
   assign target_voltage_select   = cfg_reg[CFG_TVS_LSB +: 3];

   // Byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // AXI write channel capture
   logic        aw_have_reg;
   logic        w_have_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        do_write;
   logic        wr_ctrl;
   logic        wr_cfg;
   logic        wr_ok;
   assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign wr_ctrl  = do_write && (awaddr_reg == OFF_CTRL);
   assign wr_cfg   = do_write && (awaddr_reg == OFF_CFG);
   assign wr_ok    = wr_ctrl || wr_cfg || (awaddr_reg == OFF_STATUS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
      end else begin
         s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register storage; enable low restores defaults
   always_ff @(posedge aclk) begin
      if (srst) begin
         ctrl_reg <= CTRL_RST;
         cfg_reg  <= CFG_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
         end
         if (wr_cfg) begin
            cfg_reg <= merge(cfg_reg, wdata_reg, wstrb_reg);
         end
      end
   end

   // Mode decode, discharge first
   logic      fill_req;
   logic      torch_ok;
   fls_mode_e mode_next;
   fls_mode_e mode_reg;
   assign fill_req = en_s && (fill_s || fill_bit);
   assign torch_ok = fill_req && steady_bit && !burst_bit && (drain_select == DRAIN_NONE);
   assign mode_next =
      (drain_select == DRAIN_TO_MID || drain_select == DRAIN_TO_GND) ? MODE_DRAIN :
      (burst_bit && !steady_bit) ? MODE_FLASH :
      (torch_ok && target_voltage_select == TVS_BYPASS) ? MODE_BYPASS :
      torch_ok ? MODE_TORCH :
      fill_req ? MODE_CHARGE : MODE_IDLE;

   // Mode register, resampled every clock
   always_ff @(posedge aclk) begin
      if (srst) begin
         mode_reg <= MODE_IDLE;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Charge phase sequencer
   fls_phase_e phase_reg;
   fls_phase_e phase_next;
   logic       charge_allowed;
   assign charge_allowed = fill_req && (mode_next != MODE_DRAIN);
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         PH_OFF: begin
            if (charge_allowed) begin
               phase_next = PH_PRECHARGE;
            end
         end
         PH_PRECHARGE: begin
            if (cmp.above_low) begin
               phase_next = PH_LINEAR;
            end
         end
         PH_LINEAR: begin
            if (cmp.above_vin) begin
               phase_next = PH_BOOST;
            end
         end
         PH_BOOST: begin
            if (cmp.at_target) begin
               phase_next = PH_FULL;
            end
         end
         PH_FULL: begin
            if (!cmp.above_99) begin
               phase_next = PH_PRECHARGE;
            end
         end
         default: phase_next = PH_OFF;
      endcase
      if (!charge_allowed) begin
         phase_next = PH_OFF;
      end
   end

   always_ff @(posedge aclk) begin
      if (srst) begin
         phase_reg <= PH_OFF;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // Full indicator: falls at target, rises below 96 percent
   logic full_next;
   assign full_next = cmp.at_target ? 1'b0 :
                      !cmp.above_96 ? 1'b1 : full_indicator;

   // Power stage controls from next phase and mode
   fls_pwr_s pwr_next;
   logic     boosting;
   assign boosting = (phase_next == PH_BOOST) || (mode_next == MODE_TORCH);
   always_comb begin
      pwr_next              = '0;
      pwr_next.fixed_charge = (phase_next == PH_PRECHARGE);
      pwr_next.set_charge   = (phase_next == PH_LINEAR);
      pwr_next.fill_current = fill_current;
      pwr_next.boost_on     = boosting && (mode_next != MODE_BYPASS);
      pwr_next.pwm_mode     = pwr_next.boost_on && cmp.above_120;
      pwr_next.peak_select  = inductor_peak_select;
      pwr_next.peak_clamp   = pwr_next.boost_on && cmp.above_5v;
      pwr_next.peak_1000ma  = high_output_peak_select;
      pwr_next.led_flash    = (mode_next == MODE_FLASH);
      pwr_next.led_torch    = (mode_next == MODE_TORCH) || (mode_next == MODE_BYPASS);
      pwr_next.drain_on     = (mode_next == MODE_DRAIN);
      pwr_next.drain_to_gnd = (drain_select == DRAIN_TO_GND);
   end

   // Output flops
   always_ff @(posedge aclk) begin
      if (srst) begin
         pwr_out        <= '0;
         full_indicator <= 1'b1;
         mode_out       <= MODE_IDLE;
      end else begin
         pwr_out        <= pwr_next;
         full_indicator <= full_next;
         mode_out       <= mode_next;
      end
   end

   // Read channel
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic        rd_hit;
   assign status_word = {21'h0, full_indicator, 2'h0, 1'b0, phase_reg, 1'b0, mode_reg};
   assign rd_hit  = (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_CFG) || (s_axi_araddr == OFF_STATUS);
   assign rd_word = (s_axi_araddr == OFF_CTRL) ? ctrl_reg :
                    (s_axi_araddr == OFF_CFG)  ? cfg_reg  :
                    (s_axi_araddr == OFF_STATUS) ? status_word : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   a_drain_override: assert property (@(posedge aclk) disable iff (srst)
      (drain_select == DRAIN_TO_MID) |=> (mode_out == MODE_DRAIN && !pwr_out.led_flash && !pwr_out.fixed_charge))
      else $error("drain did not override");
   a_flash_decode: assert property (@(posedge aclk) disable iff (srst)
      (burst_bit && !steady_bit && drain_select == DRAIN_NONE) |=> pwr_out.led_flash)
      else $error("flash not entered");
   a_bypass_boost: assert property (@(posedge aclk) disable iff (srst)
      (mode_out == MODE_BYPASS) |-> !pwr_out.boost_on && pwr_out.led_torch)
      else $error("boost ran in bypass torch");
   a_torch_boost: assert property (@(posedge aclk) disable iff (srst)
      (mode_out == MODE_TORCH) |-> pwr_out.boost_on)
      else $error("torch without boost");
   a_charge_start: assert property (@(posedge aclk) disable iff (srst)
      ($rose(fill_req) && drain_select == DRAIN_NONE && phase_reg == PH_OFF) |=> pwr_out.fixed_charge)
      else $error("charge did not start");
   a_precharge_exit: assert property (@(posedge aclk) disable iff (srst)
      (phase_reg == PH_PRECHARGE && cmp.above_low && charge_allowed) |=> pwr_out.set_charge)
      else $error("stuck in fixed charge");
   a_full_falls: assert property (@(posedge aclk) disable iff (srst)
      cmp.at_target |=> !full_indicator)
      else $error("full indicator not low at target");
   a_full_rises: assert property (@(posedge aclk) disable iff (srst)
      (!cmp.above_96 && !cmp.at_target) |=> full_indicator)
      else $error("full indicator not high below 96 percent");
   a_power_down: assert property (@(posedge aclk) disable iff (srst)
      !fill_req |=> (!pwr_out.boost_on || mode_out == MODE_TORCH) && !pwr_out.fixed_charge && !pwr_out.set_charge)
      else $error("power stage on without request");
   a_recharge_99: assert property (@(posedge aclk) disable iff (srst)
      (phase_reg == PH_FULL && !cmp.above_99 && charge_allowed) |=> phase_reg == PH_PRECHARGE)
      else $error("no recharge at 99 percent");
   a_pwm_select: assert property (@(posedge aclk) disable iff (srst)
      pwr_out.pwm_mode |-> pwr_out.boost_on)
      else $error("pwm without boost");
   a_reset_hold: assert property (@(posedge aclk)
      (aresetn && !en_s) |=> (mode_out == MODE_IDLE && ctrl_reg == CTRL_RST))
      else $error("enable low did not reset");
   c_charge_full: cover property (@(posedge aclk) disable iff (srst) phase_reg == PH_BOOST ##1 phase_reg == PH_FULL);
   c_flash: cover property (@(posedge aclk) disable iff (srst) mode_out == MODE_FLASH);
   c_drain_charge: cover property (@(posedge aclk) disable iff (srst) mode_out == MODE_CHARGE ##1 mode_out == MODE_DRAIN);
   c_bypass: cover property (@(posedge aclk) disable iff (srst) mode_out == MODE_BYPASS);

endmodule : fls_sequencer
`default_nettype wire

// file: src/fls_pkg.sv
// Package for the flash LED mode and charge sequencer
`default_nettype none
package fls_pkg;
   // Drain select encodings
   localparam logic [1:0] DRAIN_NONE      = 2'h0;
   localparam logic [1:0] DRAIN_TO_MID    = 2'h1;
   localparam logic [1:0] DRAIN_TO_GND    = 2'h2;
   // Target voltage select meaning bypass torch
   localparam logic [2:0] TVS_BYPASS      = 3'h0;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL        = 8'h00;
   localparam logic [7:0] OFF_CFG         = 8'h04;
   localparam logic [7:0] OFF_STATUS      = 8'h08;
   // Control register fields
   localparam int CTRL_FILL_BIT   = 0;
   localparam int CTRL_BURST_BIT  = 1;
   localparam int CTRL_STEADY_BIT = 2;
   localparam int CTRL_DRAIN_LSB  = 4;
   // Config register fields
   localparam int CFG_FILL_I_LSB  = 0;
   localparam int CFG_PEAK_LSB    = 4;
   localparam int CFG_HIGH_PK_BIT = 8;
   localparam int CFG_TVS_LSB     = 12;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST  = 32'h0000_0000;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Reset low time and clock rate
   localparam int RESET_LOW_NS = 300;
   localparam int CLK_PERIOD_NS = 40;
   localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Operating modes
   typedef enum logic [2:0] {
      MODE_IDLE, MODE_CHARGE, MODE_FLASH, MODE_TORCH, MODE_BYPASS, MODE_DRAIN
   } fls_mode_e;
   // Charge phases
   typedef enum logic [2:0] {
      PH_OFF, PH_PRECHARGE, PH_LINEAR, PH_BOOST, PH_FULL
   } fls_phase_e;
   // Comparator inputs, one per output voltage threshold
   typedef struct packed {
      logic above_low;     // Output above 0.2 V
      logic above_vin;     // Output above input minus 0.1 V
      logic above_120;     // Output above 120 percent of input
      logic above_5v;      // Output above 5.0 V
      logic at_target;     // Output at target
      logic above_99;      // Output above 99 percent of target
      logic above_96;      // Output above 96 percent of target
   } fls_cmp_s;
   // Power stage controls
   typedef struct packed {
      logic       fixed_charge;   // Fixed 200 mA charge
      logic       set_charge;     // Programmed charge current
      logic [1:0] fill_current;
      logic       boost_on;
      logic       pwm_mode;       // Zero means PFM
      logic [2:0] peak_select;
      logic       peak_clamp;     // Clamp above 5.0 V
      logic       peak_1000ma;    // Clamp value: 1000 mA, else 500 mA
      logic       led_flash;
      logic       led_torch;
      logic       drain_on;
      logic       drain_to_gnd;
   } fls_pwr_s;
endpackage : fls_pkg
`default_nettype wire

// file: tb/fls_cap_model.sv
// Storage capacitor and comparator model driven by the power stage controls
`default_nettype none
module fls_cap_model
   import fls_pkg::*;
#(
   parameter int VIN_MV    = 3700,
   parameter int TARGET_MV = 5500
)(
   input  wire logic     aclk,
   input  wire logic     aresetn,
   input  wire fls_pwr_s pwr,
   output wire fls_cmp_s cmp
);
   timeunit 1ns;
   timeprecision 1ns;
   int v = 0;
   int fl;
   // Drain floor: ground or mid level
   always_comb fl = pwr.drain_to_gnd ? 0 : 2500;
   // Output voltage in mV, slow leak when nothing runs
   always @(posedge aclk) begin
      if (!aresetn) v <= 0;
      else if (pwr.drain_on) v <= (v - 5 > fl) ? v - 5 : fl;
      else if (pwr.boost_on) v <= v + 3;
      else if (pwr.set_charge) v <= v + 2;
      else if (pwr.fixed_charge) v <= v + 1;
      else if (v > 0) v <= v - 1;
   end
   // One comparator level per threshold
   assign cmp = {v >= 200, v >= VIN_MV - 100, v * 10 > VIN_MV * 12, v >= 5000,
                 v >= TARGET_MV, v * 100 >= TARGET_MV * 99, v * 100 >= TARGET_MV * 96};
endmodule : fls_cap_model
`default_nettype wire

// file: tb/flash_led_mode_and_charge_sequencer_tb.sv
// Self-checking testbench for the mode decoder and charge sequencer
`default_nettype none
module flash_led_mode_and_charge_sequencer_tb
   import fls_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, enable_pin, fill_pin;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, cfg;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   wire fls_cmp_s cmp_in;
   fls_pwr_s    pwr_out;
   logic        full_indicator;
   fls_mode_e   mode_out;
   logic [33:0] exp_q[$], msk_q[$], m;
   int          failures, compares, n;
   int          cycles = 0;
   logic [31:0] tctl[8] = '{32'h01, 32'h02, 32'h05, 32'h05, 32'h13, 32'h20, 32'h31, 32'h00};
   logic [31:0] tcfg[8] = '{32'h1000, 32'h1000, 32'h1000, 32'h0, 32'h1000, 32'h1000, 32'h1000, 32'h1000};
   fls_mode_e   tm[8]   = '{MODE_CHARGE, MODE_FLASH, MODE_TORCH, MODE_BYPASS, MODE_DRAIN, MODE_DRAIN,
                            MODE_CHARGE, MODE_IDLE};
   localparam logic [33:0] ALL = 34'h3_FFFF_FFFF;

   fls_sequencer uut (.aclk(aclk), .aresetn(aresetn), .enable_pin(enable_pin), .fill_pin(fill_pin),
      .cmp_in(cmp_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwr_out(pwr_out), .full_indicator(full_indicator),
      .mode_out(mode_out));

   fls_cap_model cap (.aclk(aclk), .aresetn(aresetn), .pwr(pwr_out), .cmp(cmp_in));

   // Clock, 40 ns period
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task chk(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task finish_test();
      $display("Comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   // Bus write, response noted for the monitor
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, 32'h0});
      msk_q.push_back({2'h3, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   // Bus read, masked expectation noted for the monitor
   task rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] mk);
      exp_q.push_back(e);
      msk_q.push_back(mk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   // Monitor: compares each bus answer with the oldest note
   always @(posedge aclk) begin
      if ((bvalid && bready) || (rvalid && rready)) begin
         m = msk_q.pop_front();
         chk(((bvalid && bready) ? {bresp, 32'h0} : {rresp, rdata}) & m, exp_q.pop_front() & m);
      end
   end

   // Hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 70000) begin
         failures++;
         finish_test();
      end
   end

   // Main sequence
   initial begin
      aresetn = 1'b0; enable_pin = 1'b0; fill_pin = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
      failures = 0; compares = 0;
      cfg = $urandom(41);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      enable_pin <= 1'b1;
      @(posedge aclk);
      chk(34'(full_indicator), 34'h1);
      chk(34'(mode_out), 34'(MODE_IDLE));
      repeat (25000) @(posedge aclk);
      rd(OFF_CTRL, {RESP_OKAY, CTRL_RST}, ALL);
      rd(OFF_CFG, {RESP_OKAY, CFG_RST}, ALL);
      wr(8'h0C, 32'h1, RESP_SLVERR);
      rd(8'h0C, {RESP_SLVERR, 32'h0}, ALL);
      wstrb <= 4'h1;
      wr(OFF_CFG, 32'hFFFF_FFFF, RESP_OKAY);
      wstrb <= 4'hF;
      rd(OFF_CFG, {RESP_OKAY, 32'h0000_00FF}, ALL);
      // Charge from the pin with random current and peak settings
      cfg = 32'h0000_5000 | ($urandom & 32'h0000_0173);
      wr(OFF_CFG, cfg, RESP_OKAY);
      fill_pin <= 1'b1;
      for (n = 0; n < 5000 && pwr_out.fixed_charge !== 1'b1; n++) @(posedge aclk);
      chk(34'({pwr_out.fixed_charge, pwr_out.set_charge}), 34'h2);
      for (n = 0; n < 5000 && pwr_out.set_charge !== 1'b1; n++) @(posedge aclk);
      chk(34'({pwr_out.fixed_charge, pwr_out.fill_current}), 34'(cfg[1:0]));
      for (n = 0; n < 5000 && pwr_out.boost_on !== 1'b1; n++) @(posedge aclk);
      chk(34'({pwr_out.pwm_mode, pwr_out.peak_select}), 34'(cfg[6:4]));
      for (n = 0; n < 5000 && pwr_out.peak_clamp !== 1'b1; n++) @(posedge aclk);
      chk(34'({pwr_out.pwm_mode, pwr_out.peak_1000ma}), 34'({1'b1, cfg[8]}));
      for (n = 0; n < 5000 && full_indicator !== 1'b0; n++) @(posedge aclk);
      chk(34'(full_indicator), 34'h0);
      repeat (4) @(posedge aclk);
      chk(34'({pwr_out.boost_on, pwr_out.set_charge}), 34'h0);
      for (n = 0; n < 5000 && pwr_out.boost_on !== 1'b1; n++) @(posedge aclk);
      chk(34'(pwr_out.boost_on), 34'h1);
      wr(OFF_CTRL, {26'h0, DRAIN_TO_MID, 4'h0}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(34'({mode_out, pwr_out.drain_on, pwr_out.boost_on}), 34'({MODE_DRAIN, 2'h2}));
      for (n = 0; n < 5000 && full_indicator !== 1'b1; n++) @(posedge aclk);
      chk(34'(full_indicator), 34'h1);
      fill_pin <= 1'b0;
      wr(OFF_CTRL, 32'h0, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk(34'({pwr_out.fixed_charge, pwr_out.set_charge, pwr_out.boost_on}), 34'h0);
      // Every mode code through the register bits
      for (int i = 0; i < 8; i++) begin
         wr(OFF_CFG, tcfg[i], RESP_OKAY);
         wr(OFF_CTRL, tctl[i], RESP_OKAY);
         rd(OFF_STATUS, 34'(tm[i]), 34'h7);
         chk(34'({pwr_out.led_flash, pwr_out.led_torch, pwr_out.drain_on, pwr_out.drain_to_gnd}),
             34'({tm[i] == MODE_FLASH, tm[i] inside {MODE_TORCH, MODE_BYPASS}, tm[i] == MODE_DRAIN,
                  tctl[i][5:4] == DRAIN_TO_GND}));
      end
      // Enable low in mid-run resets the settings
      wr(OFF_CTRL, 32'h2, RESP_OKAY);
      enable_pin <= 1'b0;
      repeat (8) @(posedge aclk);
      chk(34'(mode_out), 34'(MODE_IDLE));
      enable_pin <= 1'b1;
      repeat (25000) @(posedge aclk);
      rd(OFF_CTRL, {RESP_OKAY, CTRL_RST}, ALL);
      finish_test();
   end
endmodule : flash_led_mode_and_charge_sequencer_tb
`default_nettype wire
